// >>> rtl/led_bank_pwm_serial_control.v
// two-bank, sixteen-channel led pwm logic fed by a cascadable 36-bit serial chain
// assumes the chain pins are asynchronous to ref_clk and slow (shift clock well
// under ref_clk / 8); analog current setting lives outside this block
`timescale 1ns/100ps
`include "led_pwm_defines.vh"

module led_bank_pwm_serial_control #(
    // ref_clk cycles without a shift edge before the watchdog trips
    parameter WD_TIMEOUT_CYCLES = (`WD_TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    // revision code, value arbitrary
    parameter [`REV_W-1:0] REVISION = 3'h5
)
(
    input wire ref_clk,
    input wire rstn,
    input wire serial_shift_clock,
    input wire serial_data_in,
    input wire load,
    input wire [15:0] open_circuit,
    input wire overtemp,
    output reg serial_data_out,
    output reg [15:0] led_on,
    output reg [`LEVEL_W-1:0] bank_a_level,
    output reg [`LEVEL_W-1:0] bank_b_level,
    output reg watchdog_fault
);

    // three-stage synchronisers; stage one feeds stage two only
    reg [2:0] sync_clk;
    reg [2:0] sync_din;
    reg [2:0] sync_load;
    reg [2:0] sync_hot;
    reg [15:0] sync_open1;
    reg [15:0] sync_open2;
    reg [15:0] sync_open3;

    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sync_clk <= 3'h0;
            sync_din <= 3'h0;
            sync_load <= 3'h0;
            sync_hot <= 3'h0;
            sync_open1 <= 16'h0000;
            sync_open2 <= 16'h0000;
            sync_open3 <= 16'h0000;
        end
        else
        begin
            sync_clk <= {sync_clk[1:0], serial_shift_clock};
            sync_din <= {sync_din[1:0], serial_data_in};
            sync_load <= {sync_load[1:0], load};
            sync_hot <= {sync_hot[1:0], overtemp};
            sync_open1 <= open_circuit;
            sync_open2 <= sync_open1;
            sync_open3 <= sync_open2;
        end
    end

    // the opens bus uses a majority filter with hold instead of per-bit enables
    // a level counts once stages two and three agree
    reg din_level;
    reg load_level;
    reg hot_level;
    reg [15:0] open_level;
    // edges compare stages two and three, the same pair the levels use
    wire shift_rise = sync_clk[1] & ~sync_clk[2];
    wire shift_fall = ~sync_clk[1] & sync_clk[2];

    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            din_level <= 1'b0;
            load_level <= 1'b0;
            hot_level <= 1'b0;
            open_level <= 16'h0000;
        end
        else
        begin
            if (sync_din[1] == sync_din[2])
                din_level <= sync_din[2];
            if (sync_load[1] == sync_load[2])
                load_level <= sync_load[2];
            if (sync_hot[1] == sync_hot[2])
                hot_level <= sync_hot[2];
            open_level <= (sync_open2 & sync_open3) | (open_level & (sync_open2 | sync_open3));
        end
    end

    // data and load are settled a ref_clk before the edge is seen,
    // so din_level/load_level line up with the detected edge
    reg [`WORD_W-1:0] shift_word;
    reg captured;
    reg [`WORD_W-1:0] cap_word;
    reg cap_valid;
    wire buf_in_ready;

    // the fault flag clears on the first shift edge, long before a host
    // can read status back, so the status word takes a sticky copy
    reg wd_seen;
    wire status_load = shift_rise && load_level && captured;

    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            wd_seen <= 1'b0;
        else if (watchdog_fault)
            wd_seen <= 1'b1;
        else if (status_load)
            wd_seen <= 1'b0;
    end

    wire [`WORD_W-1:0] status_word = {`SW_FILL_VALUE,
                                      REVISION,
                                      hot_level,
                                      wd_seen,
                                      open_level};

    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            shift_word <= {`WORD_W{1'b0}};
            captured <= 1'b0;
            cap_word <= {`WORD_W{1'b0}};
            cap_valid <= 1'b0;
        end
        else
        begin
            if (shift_rise && !load_level)
                shift_word <= {shift_word[`WORD_W-2:0], din_level};
            else if (shift_rise && captured)
                shift_word <= status_word;
            if (!load_level)
                captured <= 1'b0;
            else if (shift_fall && !captured)
                captured <= 1'b1;
            // capture waits in cap_word while the buffer is full
            if (shift_fall && load_level && !captured)
            begin
                cap_word <= shift_word;
                cap_valid <= 1'b1;
            end
            else if (cap_valid && buf_in_ready)
                cap_valid <= 1'b0;
        end
    end

    // registered so the pin moves two ref_clk after the rise is taken;
    // a cascaded part downstream then sees it well before its next rise,
    // provided the host keeps each shift phase at four ref_clk or more
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
            serial_data_out <= 1'b0;
        else
            serial_data_out <= shift_word[`WORD_W-1];
    end

    // a word captured while both entries are full waits in cap_word;
    // a second capture before it drains overwrites it, so a host must
    // give shift clocks between loads for words to take effect
    // two-entry word buffer; drained only on pwm ticks so a setting
    // changes between counter steps, never inside one
    reg [`WORD_W-1:0] buf_mem [0:`BUF_DEPTH-1];
    reg buf_wr;
    reg buf_rd;
    reg [`BUF_CNT_W-1:0] buf_count;
    wire buf_out_valid = (buf_count != 2'h0);
    wire pwm_tick;
    wire buf_out_ready = pwm_tick;
    wire buf_push = cap_valid && buf_in_ready;
    wire buf_pop = buf_out_valid && buf_out_ready;
    wire [`WORD_W-1:0] buf_head = buf_mem[buf_rd];
    assign buf_in_ready = (buf_count != `BUF_DEPTH);

    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            buf_wr <= 1'b0;
            buf_rd <= 1'b0;
            buf_count <= 2'h0;
            buf_mem[0] <= {`WORD_W{1'b0}};
            buf_mem[1] <= {`WORD_W{1'b0}};
        end
        else
        begin
            if (buf_push)
            begin
                buf_mem[buf_wr] <= cap_word;
                buf_wr <= ~buf_wr;
            end
            if (buf_pop)
                buf_rd <= ~buf_rd;
            if (buf_push && !buf_pop)
                buf_count <= buf_count + 2'h1;
            else if (buf_pop && !buf_push)
                buf_count <= buf_count - 2'h1;
        end
    end

    // parallel control registers; they change only on a pwm tick, so a
    // new divisor never cuts a counter step short
    reg wd_disable;
    reg [`DIV_W-1:0] divisor;
    reg [`PWM_W-1:0] setting_a [0:`NUM_CH-1];
    reg [`PWM_W-1:0] setting_b [0:`NUM_CH-1];
    wire [`CH_W-1:0] head_addr = buf_head[`CW_ADDR_LSB +: `CH_W];

    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wd_disable <= 1'b0;
            divisor <= 4'h0;
            bank_a_level <= 4'h0;
            bank_b_level <= 4'h0;
        end
        else if (buf_pop)
        begin
            wd_disable <= buf_head[`CW_WD_DISABLE];
            divisor <= buf_head[`CW_DIV_LSB +: `DIV_W];
            // external current dac turns the code into code/16 of full scale
            bank_a_level <= buf_head[`CW_LEVEL_A_LSB +: `LEVEL_W];
            bank_b_level <= buf_head[`CW_LEVEL_B_LSB +: `LEVEL_W];
        end
    end

    // pwm clock: one tick every divisor+1 shift clock rising edges
    // the counter wraps freely; nothing from the host restarts a period,
    // so outputs of different parts are not phase aligned
    reg [`DIV_W-1:0] div_count;
    reg [`PWM_W-1:0] pwm_count;
    assign pwm_tick = shift_rise && (div_count == divisor);

    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            div_count <= 4'h0;
            pwm_count <= 10'h000;
        end
        else if (shift_rise)
        begin
            if (pwm_tick)
            begin
                div_count <= 4'h0;
                pwm_count <= pwm_count + 10'h001;
            end
            else
                div_count <= div_count + 4'h1;
        end
    end

    // watchdog: counts ref_clk cycles since the last shift edge
    // limitation: only shift edges count as activity, load alone does not
    // the cycle count rounds up, so a trip never comes before the minimum
    // a disabled watchdog also drops a pending fault at once
    reg [`WD_CNT_W-1:0] wd_count;

    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wd_count <= {`WD_CNT_W{1'b0}};
            watchdog_fault <= 1'b0;
        end
        else if (shift_rise || shift_fall)
        begin
            wd_count <= {`WD_CNT_W{1'b0}};
            watchdog_fault <= 1'b0;
        end
        else if (wd_disable)
        begin
            wd_count <= {`WD_CNT_W{1'b0}};
            watchdog_fault <= 1'b0;
        end
        else if (wd_count >= WD_TIMEOUT_CYCLES[`WD_CNT_W-1:0])
            watchdog_fault <= 1'b1;
        else
            wd_count <= wd_count + {{(`WD_CNT_W-1){1'b0}}, 1'b1};
    end

    // per-channel settings and comparators
    // reset settings are zero, so each output still lights at count zero;
    // a host cannot get dark outputs by writing channels, since every setting lights at count zero
    // (there is no power-on blanking of its own)
    genvar ch;
    generate
        for (ch = 0; ch < `NUM_CH; ch = ch + 1)
        begin : chan
            always @(posedge ref_clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    setting_a[ch] <= 10'h000;
                    setting_b[ch] <= 10'h000;
                    led_on[ch] <= 1'b0;
                    led_on[ch + `NUM_CH] <= 1'b0;
                end
                else
                begin
                    if (buf_pop && head_addr == ch)
                    begin
                        setting_a[ch] <= buf_head[`CW_DATA_A_LSB +: `PWM_W];
                        setting_b[ch] <= buf_head[`CW_DATA_B_LSB +: `PWM_W];
                    end
                    led_on[ch] <= (pwm_count <= setting_a[ch])
                        && !watchdog_fault && !hot_level;
                    led_on[ch + `NUM_CH] <= (pwm_count <= setting_b[ch])
                        && !watchdog_fault && !hot_level;
                end
            end
        end
    endgenerate

endmodule

// >>> rtl/led_pwm_defines.vh
// constants for the serial-controlled two-bank led pwm block
// assumes a 250 mhz ref_clk and 36-bit words on the serial chain
`ifndef LED_PWM_DEFINES_VH
`define LED_PWM_DEFINES_VH

`define WORD_W 36
`define PWM_W 10
`define CH_W 3
`define NUM_CH 8
`define LEVEL_W 4
`define DIV_W 4

// control word fields (position n of the word sits at bit n-1)
`define CW_ADDR_LSB 0
`define CW_DATA_A_LSB 3
`define CW_DATA_B_LSB 13
`define CW_WD_DISABLE 23
`define CW_DIV_LSB 24
`define CW_LEVEL_A_LSB 28
`define CW_LEVEL_B_LSB 32

// status word fields
`define SW_OPEN_A_LSB 0
`define SW_OPEN_B_LSB 8
`define SW_WD_FAULT 16
`define SW_OVERTEMP 17
`define SW_REV_LSB 18
`define SW_FILL_LSB 21
`define SW_FILL_W 15
`define SW_FILL_VALUE 15'h2aaa
`define REV_W 3

// watchdog timing
`define CLK_PERIOD_NS 4
`define WD_TIMEOUT_NS 25000
`define WD_CNT_W 16

`define BUF_DEPTH 2
`define BUF_CNT_W 2

`endif

// >>> dv/led_pwm_chk.sv
// port-level checks for the led pwm block
// assumes host chain pins change on ref_clk and shift phases of about 5 cycles
`timescale 1ns/100ps
module led_pwm_chk #(
    parameter WD_TIMEOUT_CYCLES = 50
)
(
    input wire ref_clk,
    input wire rstn,
    input wire serial_shift_clock,
    input wire overtemp,
    input wire serial_data_out,
    input wire [15:0] led_on,
    input wire [3:0] bank_a_level,
    input wire [3:0] bank_b_level,
    input wire watchdog_fault
);
    reg sck_d;
    reg [15:0] idle_cnt;
    reg [7:0] rise_cnt;
    // ages seen at the pin; the design's sync adds a few cycles on top
    always @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sck_d <= 1'b0;
            idle_cnt <= 16'h0;
            rise_cnt <= 8'hff;
        end
        else
        begin
            sck_d <= serial_shift_clock;
            if (serial_shift_clock != sck_d)
                idle_cnt <= 16'h0;
            else if (idle_cnt != 16'hffff)
                idle_cnt <= idle_cnt + 16'h1;
            if (serial_shift_clock && !sck_d)
                rise_cnt <= 8'h0;
            else if (rise_cnt != 8'hff)
                rise_cnt <= rise_cnt + 8'h1;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_fault_blanks: assert property (watchdog_fault |=> led_on == 16'h0)
        else $error("led on during watchdog fault");
    a_ot_blanks: assert property (overtemp [*8] |-> led_on == 16'h0)
        else $error("led on during over-temperature");
    a_wd_needs_idle: assert property ($rose(watchdog_fault) |-> idle_cnt >= WD_TIMEOUT_CYCLES)
        else $error("watchdog tripped too early");
    a_wd_clears_fast: assert property (watchdog_fault && idle_cnt == 16'h0 |-> ##[1:8] !watchdog_fault)
        else $error("watchdog fault not cleared by shift edge");
    a_wd_holds_quiet: assert property (watchdog_fault && idle_cnt > 16'h8 |=> watchdog_fault)
        else $error("watchdog fault dropped without shift edge");
    a_wd_falls_edge: assert property ($fell(watchdog_fault) |-> idle_cnt <= 16'h8)
        else $error("watchdog fault fell while idle");
    a_sdo_on_rise: assert property ($changed(serial_data_out) |-> rise_cnt <= 8'ha)
        else $error("serial out moved away from a rising edge");
    a_level_on_tick: assert property ($changed({bank_b_level, bank_a_level}) |-> rise_cnt <= 8'hc)
        else $error("level code changed away from a tick");
endmodule

bind led_bank_pwm_serial_control led_pwm_chk #(.WD_TIMEOUT_CYCLES(WD_TIMEOUT_CYCLES)) i_chk (
    .ref_clk(ref_clk), .rstn(rstn), .serial_shift_clock(serial_shift_clock),
    .overtemp(overtemp), .serial_data_out(serial_data_out), .led_on(led_on),
    .bank_a_level(bank_a_level), .bank_b_level(bank_b_level), .watchdog_fault(watchdog_fault));

// >>> dv/host_link.sv
// host model of the serial chain: shifts words, loads, reads status back
// assumes ref_clk is free running; shift clock stands still between calls
`timescale 1ns/100ps
module host_link #(
    parameter integer HALF = 5
)
(
    input wire ref_clk,
    input wire serial_data_out,
    output reg serial_shift_clock,
    output reg serial_data_in,
    output reg load,
    output reg [35:0] rd_word,
    output reg rd_valid
);
    initial
    begin
        serial_shift_clock = 1'b0;
        serial_data_in = 1'b0;
        load = 1'b0;
        rd_word = 36'h0;
        rd_valid = 1'b0;
    end
    task hold(input integer c);
    begin
        repeat (c) @(posedge ref_clk);
        #1;
    end
    endtask
    task pulse;
    begin
        serial_shift_clock = 1'b1;
        hold(HALF);
        serial_shift_clock = 1'b0;
        hold(HALF);
    end
    endtask
    task shift(input [35:0] w, input rd_en);
        integer i;
        reg [35:0] r;
    begin
        for (i = 35; i >= 0; i = i - 1)
        begin
            serial_data_in = w[i];
            hold(HALF);
            r[i] = serial_data_out;
            pulse;
        end
        // hold window over, so no stale level is left on the line
        serial_data_in = ~w[0];
        rd_word = r;
        rd_valid = rd_en;
        hold(1);
        rd_valid = 1'b0;
    end
    endtask
    // first rise is ignored, fall captures, second rise loads status
    task load_word;
    begin
        load = 1'b1;
        hold(HALF);
        pulse;
        pulse;
        load = 1'b0;
        hold(HALF);
    end
    endtask
endmodule

// >>> dv/tb_top.sv
// testbench for the led pwm block with the host model on the chain
// assumes a 250 mhz ref_clk and a shortened watchdog count of 50
`timescale 1ns/100ps
`include "led_pwm_defines.vh"
module tb_top;
    localparam [2:0] REV = 3'h2;
    reg ref_clk = 1'b0;
    reg rstn = 1'b0;
    reg [15:0] open_circuit = 16'h0;
    reg overtemp = 1'b0;
    wire serial_shift_clock, serial_data_in, load, serial_data_out, watchdog_fault, rd_valid;
    wire [15:0] led_on;
    wire [3:0] bank_a_level, bank_b_level;
    wire [35:0] rd_word;
    integer err_total = 0;
    integer check_count = 0;
    integer seed = 61;
    integer k, a, n;
    reg [35:0] w;
    reg [15:0] mask;
    reg [7:0] lv, lv_prev;
    reg [35:0] exp_q [$];
    led_bank_pwm_serial_control #(.WD_TIMEOUT_CYCLES(50), .REVISION(REV)) i_dut (
        .ref_clk(ref_clk), .rstn(rstn), .serial_shift_clock(serial_shift_clock),
        .serial_data_in(serial_data_in), .load(load), .open_circuit(open_circuit),
        .overtemp(overtemp), .serial_data_out(serial_data_out), .led_on(led_on),
        .bank_a_level(bank_a_level), .bank_b_level(bank_b_level),
        .watchdog_fault(watchdog_fault));
    host_link #(.HALF(5)) i_host (
        .ref_clk(ref_clk), .serial_data_out(serial_data_out),
        .serial_shift_clock(serial_shift_clock), .serial_data_in(serial_data_in),
        .load(load), .rd_word(rd_word), .rd_valid(rd_valid));
    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end
    task cmp(input [35:0] got, input [35:0] exp);
    begin
        check_count = check_count + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    task idle(input integer c);
    begin
        repeat (c) @(posedge ref_clk);
        #1;
    end
    endtask
    task close_out;
    begin
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask
    always @(posedge ref_clk)
    begin
        if (rd_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                cmp(rd_word, ~rd_word);
            else
                cmp(rd_word, exp_q.pop_front());
        end
    end
    initial
    begin
        mask = 16'h0;
        lv_prev = 8'h0;
        idle(4);
        rstn = 1'b1;
        idle(8);
        for (k = 0; k < 7; k = k + 1)
        begin
            a = k * 3 + 1;
            open_circuit = $random(seed);
            lv = $random(seed);
            // last loaded word: watchdog on, divide by two
            w = {lv, (k == 5) ? 4'h1 : {3'h0, k[0]}, (k == 5) ? 1'b0 : 1'b1, 20'hfffff, a[2:0]};
            i_host.shift(w, k > 0);
            if (k > 0)
            begin
                cmp({bank_b_level, bank_a_level}, lv_prev);
                cmp(led_on & mask, mask);
            end
            mask = mask | (16'h0101 << a[2:0]);
            lv_prev = lv;
            if (k == 1)
            begin
                idle(60);
                cmp(watchdog_fault, 1'b0);
            end
            if (k == 3)
            begin
                overtemp = 1'b1;
                idle(12);
                cmp(led_on, 16'h0);
            end
            if (k < 6)
            begin
                i_host.load_word;
                exp_q.push_back({`SW_FILL_VALUE, REV, overtemp, 1'b0, open_circuit});
            end
            overtemp = 1'b0;
        end
        // channel 3 is never written, so it lights only at count zero
        for (k = 0; k < 2; k = k + 1)
        begin
            n = 0;
            while (led_on[3] !== 1'b0 && n < 5000)
            begin
                i_host.pulse;
                n = n + 1;
            end
            while (led_on[3] !== 1'b1 && n < 5000)
            begin
                i_host.pulse;
                n = n + 1;
            end
        end
        cmp(n, 2048);
        idle(45);
        cmp(watchdog_fault, 1'b0);
        idle(15);
        cmp({watchdog_fault, led_on}, 17'h10000);
        i_host.pulse;
        idle(8);
        cmp(watchdog_fault, 1'b0);
        // the timeout must still show in the next status word
        i_host.load_word;
        exp_q.push_back({`SW_FILL_VALUE, REV, 1'b0, 1'b1, open_circuit});
        i_host.shift(36'h0, 1'b1);
        idle(2);
        close_out;
    end
endmodule
